// ---- rtl/async_serial_mp_transceiver.sv ----
// Asynchronous transmit/receive engine with multiprocessor addressing.
// Assumes software drives the control pulses synchronously to clk_sys_i and
// changes format inputs only while tx_enable_i and rx_enable_i are low.
`timescale 1ns/1ps
`default_nettype none
module async_serial_mp_transceiver #(
  parameter int DIV_W = serial_unit_pkg::BAUD_DIV_W
) (
  input  wire logic             clk_sys_i,            // System clock, 200 MHz
  input  wire logic             resetn_i,             // Synchronous reset, low
  input  wire logic [DIV_W-1:0] baud_div_i,           // Tick divisor
  input  wire logic             tx_enable_i,          // Transmitter on
  input  wire logic             rx_enable_i,          // Receiver on
  input  wire logic             char7_i,              // 7-bit characters
  input  wire logic             parity_en_i,          // Parity bit present
  input  wire logic             parity_odd_select_i,  // Odd parity
  input  wire logic             mp_format_i,          // Multiprocessor format
  input  wire logic             two_stop_i,           // Two stop bits
  input  wire logic             tx_empty_irq_en_i,    // Enable tx_empty_irq
  input  wire logic             tx_end_irq_en_i,      // Enable tx_end_irq
  input  wire logic             rx_irq_en_i,          // Enable rx irqs
  input  wire logic             tx_write_i,           // Write tx_holding_reg
  input  wire logic [7:0]       tx_data_i,            // Byte to write
  input  wire logic             mp_bit_to_send_i,     // Mp bit for next byte
  input  wire logic             tx_holding_clear_i,   // Clear tx_holding_empty
  input  wire logic             rx_full_clear_i,      // Clear rx_holding_full
  input  wire logic             overrun_clear_i,      // Clear overrun_flag
  input  wire logic             framing_clear_i,      // Clear framing_error_flag
  input  wire logic             parity_clear_i,       // Clear parity_error_flag
  input  wire logic             addr_wait_set_i,      // Set addr_wait_en
  input  wire logic             rx_line_i,            // Receive pin
  output logic                  tx_line_o,            // Transmit pin
  output logic                  tx_holding_empty_o,   // Holding register free
  output logic                  tx_end_flag_o,        // Transmission ended
  output logic                  rx_holding_full_o,    // Byte waiting
  output logic [7:0]            rx_holding_reg_o,     // Received byte
  output logic                  mp_bit_o,             // Received mp bit
  output logic                  overrun_flag_o,       // Overrun error
  output logic                  framing_error_flag_o, // Framing error
  output logic                  parity_error_flag_o,  // Parity error
  output logic                  addr_wait_en_o,       // Waiting for ID frame
  output logic                  tx_empty_irq_o,       // Transmit empty request
  output logic                  tx_end_irq_o,         // Transmit end request
  output logic                  rx_full_irq_o,        // Receive full request
  output logic                  rx_error_irq_o        // Receive error request
);
  typedef enum logic [4:0] {
    TX_IDLE  = 5'b00001,
    TX_START = 5'b00010,
    TX_DATA  = 5'b00100,
    TX_EXTRA = 5'b01000,
    TX_STOP  = 5'b10000
  } tx_state_e;

  typedef enum logic [4:0] {
    RX_IDLE  = 5'b00001,
    RX_START = 5'b00010,
    RX_DATA  = 5'b00100,
    RX_EXTRA = 5'b01000,
    RX_STOP  = 5'b10000
  } rx_state_e;

  serial_tick_if tk ();

  serial_bit_clock #(.DIV_W(DIV_W)) u_bit_clock (
    .clk_sys_i  (clk_sys_i),
    .resetn_i   (resetn_i),
    .baud_div_i (baud_div_i),
    .rx_line_i  (rx_line_i),
    .tk         (tk)
  );

  // Even parity of a character; 7-bit mode ignores the top bit
  function automatic logic parity_of(input logic [7:0] d, input logic c7);
    parity_of = ^(c7 ? {1'b0, d[6:0]} : d);
  endfunction

  tx_state_e   tx_state;
  rx_state_e   rx_state;
  logic [7:0]  tx_holding_reg;
  logic        tx_mp_hold;
  logic [7:0]  tx_shift_reg;
  logic        tx_mp;
  logic [3:0]  tx_tick;
  logic [2:0]  tx_idx;
  logic        tx_stop2;
  logic [7:0]  rx_shift_reg;
  logic [3:0]  rx_tick;
  logic [2:0]  rx_idx;
  logic        rx_extra;
  logic        rx_prev;

  // Multiprocessor format overrides parity settings
  logic       has_extra;
  logic [2:0] bit_last;
  logic       tx_bit_end;
  logic       tx_load;
  logic       rx_sample;
  logic       rx_any_err;
  logic       rx_done;
  logic       rx_skip;
  logic       rx_par_bad;
  assign has_extra  = mp_format_i | parity_en_i;
  assign bit_last   = char7_i ? serial_unit_pkg::BIT_LAST_7 : serial_unit_pkg::BIT_LAST_8;
  assign tx_bit_end = tk.tick16 && (tx_tick == serial_unit_pkg::TICK_LAST);
  assign tx_load    = tx_enable_i && !tx_holding_empty_o &&
                      (tx_state == TX_IDLE || (tx_state == TX_STOP && tx_bit_end &&
                       (tx_stop2 || !two_stop_i)));
  assign rx_sample  = tk.tick16 && (rx_tick == serial_unit_pkg::SAMPLE_TICK);
  assign rx_any_err = overrun_flag_o | framing_error_flag_o | parity_error_flag_o;
  assign rx_done    = (rx_state == RX_STOP) && rx_sample;
  assign rx_skip    = addr_wait_en_o && mp_format_i && !rx_extra;
  assign rx_par_bad = !mp_format_i && parity_en_i &&
                      ((parity_of(rx_shift_reg, char7_i) ^ rx_extra) != parity_odd_select_i);

  // Holding register written by software
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      tx_holding_reg <= serial_unit_pkg::DATA_RESET;
      tx_mp_hold     <= 1'b0;
    end
    else if (tx_write_i)
    begin
      tx_holding_reg <= tx_data_i;
      tx_mp_hold     <= mp_bit_to_send_i;
    end
  end

  // Empty flag: hardware set beats the software clear
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
      tx_holding_empty_o <= 1'b1;
    else if (!tx_enable_i || tx_load)
      tx_holding_empty_o <= 1'b1;
    else if (tx_holding_clear_i)
      tx_holding_empty_o <= 1'b0;
  end

  // End flag raised at the start of the final stop bit when nothing waits
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
      tx_end_flag_o <= 1'b1;
    else if (tx_state == TX_STOP && (tx_stop2 || !two_stop_i) && tk.tick16 &&
             tx_tick == 4'h0 && tx_holding_empty_o)
      tx_end_flag_o <= 1'b1;
    else if (tx_holding_clear_i)
      tx_end_flag_o <= 1'b0;
  end

  // Transmit sequencer; each bit lasts sixteen ticks
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i || !tx_enable_i)
    begin
      tx_state     <= TX_IDLE;
      tx_shift_reg <= serial_unit_pkg::DATA_RESET;
      tx_mp        <= 1'b0;
      tx_tick      <= 4'h0;
      tx_idx       <= 3'h0;
      tx_stop2     <= 1'b0;
      tx_line_o    <= serial_unit_pkg::LINE_MARK;
    end
    else if (tx_load)
    begin
      tx_state     <= TX_START;
      tx_shift_reg <= tx_holding_reg;
      tx_mp        <= tx_mp_hold;
      tx_tick      <= 4'h0;
      tx_idx       <= 3'h0;
      tx_stop2     <= 1'b0;
      tx_line_o    <= serial_unit_pkg::LINE_SPACE;
    end
    else
    begin
      if (tk.tick16)
        tx_tick <= tx_tick + 4'h1;
      case (tx_state)
        TX_IDLE:
          tx_line_o <= serial_unit_pkg::LINE_MARK;
        TX_START:
          if (tx_bit_end)
          begin
            tx_state  <= TX_DATA;
            tx_line_o <= tx_shift_reg[0];
          end
        TX_DATA:
          if (tx_bit_end)
          begin
            tx_idx <= tx_idx + 3'h1;
            if (tx_idx == bit_last)
            begin
              tx_state  <= has_extra ? TX_EXTRA : TX_STOP;
              tx_line_o <= mp_format_i ? tx_mp :
                           has_extra ? (parity_of(tx_shift_reg, char7_i) ^ parity_odd_select_i) :
                           serial_unit_pkg::LINE_MARK;
            end
            else
              tx_line_o <= tx_shift_reg[tx_idx + 3'h1];
          end
        TX_EXTRA:
          if (tx_bit_end)
          begin
            tx_state  <= TX_STOP;
            tx_line_o <= serial_unit_pkg::LINE_MARK;
          end
        TX_STOP:
          if (tx_bit_end)
          begin
            if (two_stop_i && !tx_stop2)
              tx_stop2 <= 1'b1;
            else
              tx_state <= TX_IDLE;
          end
        default:
          tx_state <= TX_IDLE;
      endcase
    end
  end

  // Receive sequencer; held idle while disabled or an error is pending
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      rx_state     <= RX_IDLE;
      rx_shift_reg <= serial_unit_pkg::DATA_RESET;
      rx_tick      <= 4'h0;
      rx_idx       <= 3'h0;
      rx_extra     <= 1'b0;
      rx_prev      <= serial_unit_pkg::LINE_MARK;
    end
    else
    begin
      if (tk.tick16)
        rx_prev <= tk.rx_sync;
      if (tk.tick16)
        rx_tick <= rx_tick + 4'h1;
      case (rx_state)
        RX_IDLE:
          if (rx_enable_i && !rx_any_err && tk.tick16 && rx_prev &&
              tk.rx_sync == serial_unit_pkg::LINE_SPACE)
          begin
            rx_state <= RX_START;
            rx_tick  <= 4'h1;
            rx_idx   <= 3'h0;
            rx_extra <= 1'b0;
          end
        RX_START:
          if (rx_sample)
            rx_state <= (tk.rx_sync == serial_unit_pkg::LINE_SPACE) ? RX_DATA : RX_IDLE;
        RX_DATA:
          if (rx_sample)
          begin
            rx_shift_reg[rx_idx] <= tk.rx_sync;
            if (char7_i)
              rx_shift_reg[7] <= 1'b0;
            rx_idx <= rx_idx + 3'h1;
            if (rx_idx == bit_last)
              rx_state <= has_extra ? RX_EXTRA : RX_STOP;
          end
        RX_EXTRA:
          if (rx_sample)
          begin
            rx_extra <= tk.rx_sync;
            rx_state <= RX_STOP;
          end
        RX_STOP:
          if (rx_sample)
            rx_state <= RX_IDLE;
        default:
          rx_state <= RX_IDLE;
      endcase
      if (!rx_enable_i)
        rx_state <= RX_IDLE;
    end
  end

  // Frame completion: transfer, flags and address filter
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      rx_holding_reg_o     <= serial_unit_pkg::DATA_RESET;
      mp_bit_o             <= 1'b0;
      rx_holding_full_o    <= 1'b0;
      overrun_flag_o       <= 1'b0;
      framing_error_flag_o <= 1'b0;
      parity_error_flag_o  <= 1'b0;
      addr_wait_en_o       <= 1'b0;
    end
    else
    begin
      if (rx_full_clear_i)
        rx_holding_full_o <= 1'b0;
      if (overrun_clear_i)
        overrun_flag_o <= 1'b0;
      if (framing_clear_i)
        framing_error_flag_o <= 1'b0;
      if (parity_clear_i)
        parity_error_flag_o <= 1'b0;
      if (addr_wait_set_i)
        addr_wait_en_o <= 1'b1;
      if (rx_done && !rx_skip)
      begin
        if (mp_format_i && rx_extra)
          addr_wait_en_o <= 1'b0;
        if (rx_holding_full_o)
          overrun_flag_o <= 1'b1;
        else
        begin
          rx_holding_reg_o <= rx_shift_reg;
          mp_bit_o         <= rx_extra & mp_format_i;
          if (tk.rx_sync != serial_unit_pkg::LINE_MARK)
            framing_error_flag_o <= 1'b1;
          if (rx_par_bad)
            parity_error_flag_o <= 1'b1;
          if (tk.rx_sync == serial_unit_pkg::LINE_MARK && !rx_par_bad)
            rx_holding_full_o <= 1'b1;
        end
      end
    end
  end

  // Requests are levels of flag and enable, one flop late
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      tx_empty_irq_o <= 1'b0;
      tx_end_irq_o   <= 1'b0;
      rx_full_irq_o  <= 1'b0;
      rx_error_irq_o <= 1'b0;
    end
    else
    begin
      tx_empty_irq_o <= tx_empty_irq_en_i & tx_holding_empty_o;
      tx_end_irq_o   <= tx_end_irq_en_i & tx_end_flag_o;
      rx_full_irq_o  <= rx_irq_en_i & rx_holding_full_o;
      rx_error_irq_o <= rx_irq_en_i & rx_any_err;
    end
  end

  // Checks on the frame engines
  sequence s_tx_load;
    tx_state == TX_IDLE && tx_enable_i && !tx_holding_empty_o;
  endsequence
  sequence s_rx_frame_end;
    rx_done && !rx_skip && rx_holding_full_o;
  endsequence

  property p_tx_load;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    s_tx_load |=> tx_holding_empty_o && tx_line_o == 1'b0 && tx_state == TX_START;
  endproperty
  a_tx_load: assert property (p_tx_load) else $error("load did not start frame");

  property p_start_low;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    tx_state == TX_START |-> tx_line_o == 1'b0;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start bit not low");

  property p_stop_high;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (tx_state == TX_STOP || tx_state == TX_IDLE) |-> tx_line_o;
  endproperty
  a_stop_high: assert property (p_stop_high) else $error("stop or idle not high");

  property p_mp_slot;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    tx_state == TX_EXTRA && mp_format_i |-> tx_line_o == tx_mp;
  endproperty
  a_mp_slot: assert property (p_mp_slot) else $error("mp bit slot wrong");

  property p_overrun;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    s_rx_frame_end |=> overrun_flag_o && $stable(rx_holding_reg_o);
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not handled");

  property p_err_block;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    rx_any_err && rx_state == RX_IDLE |=> rx_state == RX_IDLE;
  endproperty
  a_err_block: assert property (p_err_block) else $error("receive during error");

  property p_tx_disable;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    !tx_enable_i |=> tx_holding_empty_o && tx_state == TX_IDLE;
  endproperty
  a_tx_disable: assert property (p_tx_disable) else $error("disable left tx busy");

  property p_rx_irq;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    rx_irq_en_i && $rose(rx_holding_full_o) |-> ##1 rx_full_irq_o;
  endproperty
  a_rx_irq: assert property (p_rx_irq) else $error("rx_full_irq missing");

  property p_addr_skip;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    rx_done && rx_skip |=> $stable(rx_holding_reg_o) && !$rose(rx_holding_full_o);
  endproperty
  a_addr_skip: assert property (p_addr_skip) else $error("data frame not skipped");
endmodule
`default_nettype wire

// ---- rtl/serial_bit_clock.sv ----
// Oversampling tick divider and receive line synchroniser.
// Assumes baud_div_i is steady while the unit is enabled.
`timescale 1ns/1ps
`default_nettype none
module serial_bit_clock #(
  parameter int DIV_W = serial_unit_pkg::BAUD_DIV_W
) (
  input  wire logic             clk_sys_i,   // System clock
  input  wire logic             resetn_i,    // Synchronous reset, low
  input  wire logic [DIV_W-1:0] baud_div_i,  // Cycles per tick, minus one
  input  wire logic             rx_line_i,   // Raw receive pin
  serial_tick_if.gen            tk           // Tick and synced line
);
  logic [DIV_W-1:0] div_cnt;
  logic             rx_meta;

  // Divider; a zero divisor ticks every cycle
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      div_cnt   <= '0;
      tk.tick16 <= 1'b0;
    end
    else if (div_cnt >= baud_div_i)
    begin
      div_cnt   <= '0;
      tk.tick16 <= 1'b1;
    end
    else
    begin
      div_cnt   <= div_cnt + {{(DIV_W-1){1'b0}}, 1'b1};
      tk.tick16 <= 1'b0;
    end
  end

  // Two flops; resets to mark so no false start
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      rx_meta    <= serial_unit_pkg::LINE_MARK;
      tk.rx_sync <= serial_unit_pkg::LINE_MARK;
    end
    else
    begin
      rx_meta    <= rx_line_i;
      tk.rx_sync <= rx_meta;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/serial_tick_if.sv ----
// Carrier between the bit clock generator and the transceiver core.
// Assumes both ends share clk_sys_i.
`timescale 1ns/1ps
`default_nettype none
interface serial_tick_if;
  logic tick16;   // One-cycle pulse at 16x bit rate
  logic rx_sync;  // Receive line after two flops

  modport gen (output tick16, output rx_sync);
  modport eng (input tick16, input rx_sync);
endinterface
`default_nettype wire

// ---- rtl/serial_unit_pkg.sv ----
// Constants shared by the asynchronous serial transceiver and its bit clock.
// Assumes one system clock; all format bits are steady while the unit runs.
//
// How it works
// - Clearing tx_holding_empty marks new data; unit moves it to tx_shift_reg.
// - After the move, tx_holding_empty sets, frame starts, tx_empty_irq if enabled.
// - Frame opens with one low start bit, then 7 or 8 data bits LSB first.
// - Data is followed by parity, multiprocessor bit, or nothing, per format.
// - One or two high stop bits, then the line marks high until next start.
// - Holding register full at stop bit: next byte loads, frame follows at once.
// - Holding empty at stop bit: tx_end_flag sets, line marks, tx_end_irq if enabled.
// - Receiver detects a low start bit on rx_line and syncs bit timing to it.
// - Received data bits enter rx_shift_reg least significant bit first.
// - With parity on, count of ones must match parity_odd_select.
// - First stop bit must be 1; a second stop bit is not checked.
// - All checks pass: shift register goes to holding register, rx_holding_full sets.
// - While any receive error flag is set, reception stops and rx_holding_full does not newly set.
// - With rx_irq_en, full raises rx_full_irq; any error flag raises rx_error_irq.
// - Frame ends while full: overrun_flag sets, holding register keeps old byte.
// - Stop bit 0 sets framing_error_flag; the byte is still transferred.
// - Parity mismatch sets parity_error_flag.
// - Software clears error flags; receiver stays stopped while any remains set.
// - Multiprocessor format sends mp_bit_to_send in the parity position.
// - Multiprocessor format ignores parity enable and parity type.
// - With addr_wait_en, frames with mp_bit 0 are skipped; mp_bit 1 is accepted.
// - Receiver samples each bit on the eighth pulse of a 16x bit-rate clock.
// - Clearing tx_enable sets empty, resets shifter; rx_enable leaves rx flags alone.
// - Idle line is high; order is start, data, optional parity, stop.
package serial_unit_pkg;
  localparam int          DATA_W       = 8;             // Widest character
  localparam logic [3:0]  TICK_LAST    = 4'hF;          // Sixteen ticks per bit
  localparam logic [3:0]  SAMPLE_TICK  = 4'h7;          // Eighth pulse, bit centre
  localparam logic [2:0]  BIT_LAST_8   = 3'h7;          // Last index, 8-bit data
  localparam logic [2:0]  BIT_LAST_7   = 3'h6;          // Last index, 7-bit data
  localparam logic        LINE_MARK    = 1'b1;          // Idle and stop level
  localparam logic        LINE_SPACE   = 1'b0;          // Start bit level
  localparam logic [7:0]  DATA_RESET   = 8'h00;         // Holding/shift reset value
  localparam int          BAUD_DIV_W   = 12;            // Width of tick divisor
endpackage

// ---- tb/far_uart.sv ----
// Far-side serial peer: drives frames onto the receive pin, samples the transmit pin.
// Assumes a tick divisor of 0, so one bit lasts 16 system clocks.
`timescale 1ns/1ps
`default_nettype none
module far_uart (
  input  wire logic clk_sys_i, // System clock
  input  wire logic line_i,    // Device transmit pin
  output logic      line_o     // Device receive pin
);
  // Line marks while no frame is sent
  initial line_o = 1'b1;

  // Whole frame, LSB first, each bit 16 clocks, then back to mark
  task automatic send(input logic [10:0] f);
    for (int i = 0; i < 11; i++)
    begin
      @(posedge clk_sys_i) line_o <= f[i];
      repeat (15) @(posedge clk_sys_i);
    end
    @(posedge clk_sys_i) line_o <= 1'b1;
  endtask

  // Level start search, so a start already under way is still caught
  task automatic grab(output logic [10:0] f);
    int n;
    n = 0;
    while (line_i !== 1'b0 && n < 4000)
    begin
      @(posedge clk_sys_i);
      n++;
    end
    for (int i = 0; i < 11; i++)
    begin
      repeat (i ? 16 : 7) @(posedge clk_sys_i);
      f[i] = line_i; // Bit centre, returns mid stop
    end
  endtask
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench: transmit, receive, errors and address filtering.
// Assumes the far-side peer model and a divisor of 0 (16 clocks a bit).
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys_i = 1'b0, resetn_i = 1'b0, tx_enable_i = 1'b0, rx_enable_i = 1'b0;
  logic char7_i = 1'b0, parity_en_i = 1'b1, parity_odd_select_i = 1'b0, mp_format_i = 1'b0;
  logic two_stop_i = 1'b0, tx_empty_irq_en_i = 1'b1, tx_end_irq_en_i = 1'b1, rx_irq_en_i = 1'b1;
  logic tx_write_i = 1'b0, mp_bit_to_send_i = 1'b0, tx_holding_clear_i = 1'b0;
  logic [11:0] baud_div_i = 12'h000;
  logic [7:0]  tx_data_i = 8'h00, rx_holding_reg_o;
  logic [4:0]  clr = 5'h00; // Address set, parity, framing, overrun, full
  logic rx_line_i, tx_line_o, tx_holding_empty_o, tx_end_flag_o, rx_holding_full_o, mp_bit_o;
  logic overrun_flag_o, framing_error_flag_o, parity_error_flag_o, addr_wait_en_o;
  logic tx_empty_irq_o, tx_end_irq_o, rx_full_irq_o, rx_error_irq_o;
  logic [10:0] g1, g2;
  int err_count = 0, samples_checked = 0, cyc = 0;
  wire logic rx_full_clear_i = clr[0], overrun_clear_i = clr[1], framing_clear_i = clr[2];
  wire logic parity_clear_i = clr[3], addr_wait_set_i = clr[4];

  async_serial_mp_transceiver #(.DIV_W(12)) dut_u (.*);
  far_uart far_u (.clk_sys_i(clk_sys_i), .line_i(tx_line_o), .line_o(rx_line_i));

  // 200 MHz clock
  always #2.5 clk_sys_i = ~clk_sys_i;

  task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Start, data, extra bit, stop, as sent on the wire
  function automatic logic [10:0] fr(input logic [7:0] d, input logic x, input logic s);
    return {s, x, d, 1'b0};
  endfunction

  task automatic pulse(input logic [4:0] m);
    @(posedge clk_sys_i) clr <= m;
    @(posedge clk_sys_i) clr <= 5'h00;
  endtask

  // Write holding register, then clear the empty flag
  task automatic tx_byte(input logic [7:0] d, input logic m);
    @(posedge clk_sys_i) {tx_write_i, tx_data_i, mp_bit_to_send_i} <= {1'b1, d, m};
    @(posedge clk_sys_i) {tx_write_i, tx_holding_clear_i} <= 2'b01;
    @(posedge clk_sys_i) tx_holding_clear_i <= 1'b0;
  endtask

  // Flags packed as full, overrun, framing, parity
  task automatic rx(input logic [10:0] f, input logic [3:0] fl, input logic [7:0] h);
    far_u.send(f);
    repeat (6) @(posedge clk_sys_i);
    #1;
    chk("rx flags", {rx_holding_full_o, overrun_flag_o, framing_error_flag_o, parity_error_flag_o}, fl);
    chk("rx byte", rx_holding_reg_o, h);
  endtask

  // Format changes only while both directions are off
  task automatic fmt(input logic odd, input logic mp);
    @(posedge clk_sys_i) {tx_enable_i, rx_enable_i} <= 2'b00;
    @(posedge clk_sys_i) {parity_odd_select_i, mp_format_i, rx_irq_en_i} <= {odd, mp, ~mp};
    @(posedge clk_sys_i) {tx_enable_i, rx_enable_i} <= 2'b11;
  endtask

  // Hang guard, well above the few thousand cycles the run needs
  always @(posedge clk_sys_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      summarize();
    end
  end

  // Main sequence
  initial
  begin
    repeat (3) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    @(posedge clk_sys_i) {tx_enable_i, rx_enable_i} <= 2'b11;
    #1;
    chk("reset", {tx_line_o, tx_holding_empty_o, tx_end_flag_o, rx_holding_full_o}, 4'hE);
    tx_byte(8'hA5, 1'b0);
    fork
      begin
        far_u.grab(g1);
        chk("no end", tx_end_flag_o, 1'b0);
        far_u.grab(g2);
      end
      begin
        repeat (2) @(posedge clk_sys_i);
        #1;
        chk("load", {tx_holding_empty_o, tx_empty_irq_o, tx_line_o}, 3'h6);
        tx_byte(8'h5A, 1'b0);
      end
    join
    chk("frame 1", g1, fr(8'hA5, ^8'hA5, 1'b1));
    chk("frame 2", g2, fr(8'h5A, ^8'h5A, 1'b1));
    chk("end", {tx_end_flag_o, tx_end_irq_o}, 2'h3);
    $display("test transmit done");
    rx(fr(8'h3C, ^8'h3C, 1'b1), 4'h8, 8'h3C);
    chk("full irq", rx_full_irq_o, 1'b1);
    rx(fr(8'hC3, ^8'hC3, 1'b1), 4'hC, 8'h3C);
    chk("error irq", rx_error_irq_o, 1'b1);
    pulse(5'h01);
    rx(fr(8'h11, ^8'h11, 1'b1), 4'h4, 8'h3C);
    pulse(5'h02);
    rx(fr(8'h81, ^8'h81, 1'b0), 4'h2, 8'h81);
    pulse(5'h04);
    rx(fr(8'h7E, ~^8'h7E, 1'b1), 4'h1, 8'h7E);
    pulse(5'h08);
    fmt(1'b1, 1'b0);
    rx(fr(8'h42, ~^8'h42, 1'b1), 4'h8, 8'h42);
    $display("test receive done");
    pulse(5'h01);
    fmt(1'b1, 1'b1);
    pulse(5'h10);
    rx(fr(8'h55, 1'b0, 1'b1), 4'h0, 8'h42);
    rx(fr(8'h07, 1'b1, 1'b1), 4'h8, 8'h07);
    chk("id frame", {mp_bit_o, addr_wait_en_o, rx_full_irq_o}, 3'h4);
    tx_byte(8'h96, 1'b0);
    far_u.grab(g1);
    chk("mp frame", g1, fr(8'h96, 1'b0, 1'b1));
    $display("test multiprocessor done");
    pulse(5'h01);
    @(posedge clk_sys_i) {tx_enable_i, rx_enable_i} <= 2'b00;
    @(posedge clk_sys_i) {char7_i, two_stop_i, mp_format_i} <= 3'b110;
    @(posedge clk_sys_i) {tx_enable_i, rx_enable_i} <= 2'b11;
    tx_byte(8'h96, 1'b0);
    far_u.grab(g1);
    chk("short frame", g1, fr(8'h16, 1'b1, 1'b1));
    chk("end two stop", tx_end_flag_o, 1'b1);
    rx(fr(8'h16, 1'b1, 1'b1), 4'h8, 8'h16);
    $display("test short character done");
    tx_byte(8'h00, 1'b0);
    @(posedge clk_sys_i iff tx_holding_empty_o);
    tx_byte(8'hFF, 1'b0);
    #1;
    chk("pending", tx_holding_empty_o, 1'b0);
    @(posedge clk_sys_i) {tx_enable_i, rx_enable_i} <= 2'b00;
    repeat (2) @(posedge clk_sys_i);
    #1;
    chk("abort", {tx_holding_empty_o, tx_line_o, rx_holding_full_o}, 3'h7);
    $display("test disable done");
    summarize();
  end
endmodule
`default_nettype wire
